// >>> hw/dacsl_defines.svh
// Constants shared by both ends of the two-wire converter command port.
// Assumes a 250 MHz system clock at each end and an open-drain wire.
// Operation
// RULE_01: Master opens every transfer with start.
// RULE_02: Master holds data steady while clock high.
// RULE_03: Device matches 1001100, strap replacing bit one.
// RULE_04: Master releases ninth pulse, device acknowledges.
// RULE_05: Control byte follows address and is acknowledged.
// RULE_06: High data byte follows, device acknowledges.
// RULE_07: Low data byte completes one data word.
// RULE_08: Further byte pairs form new words.
// RULE_09: Master ends write with stop or restart.
// RULE_10: Power-down write carries mode bits seven-five.
// RULE_11: Read address makes device acknowledge, transmit.
// RULE_12: Device sends high byte first, msb first.
// RULE_13: After master acknowledge, device sends low byte.
// RULE_14: After next acknowledge, device sends control byte.
// RULE_15: Master refuses control byte; device releases line.
// RULE_16: Returned data source shown in control byte.
// RULE_17: Conversion starts at falling edge of acknowledge.
// RULE_18: Stop keeps state; await start and address.
// RULE_19: Unmatched address: no acknowledge, ignore until start.
// RULE_20: Sample on rising clock, change while low.
`ifndef DACSL_DEFINES_SVH
`define DACSL_DEFINES_SVH

// ==========================================================
// Link addressing and byte layout
`define DACSL_ADDR_HI 5'h13
`define DACSL_LAST_BIT 4'h7
`define DACSL_ACK_SLOT 4'h8
`define DACSL_C_PD 0
`define DACSL_C_BRC 2
`define DACSL_C_LD_MSB 5
`define DACSL_C_LD_LSB 4
`define DACSL_PDM_MSB 7
`define DACSL_PDM_LSB 5
`define DACSL_TX_CTRL 2'h2
`define DACSL_SY_RST 3'h7

// ==========================================================
// Controller register map and fields
`define DACSL_REG_CMD 4'h0
`define DACSL_REG_STAT 4'h4
`define DACSL_CMD_OP_MSB 9
`define DACSL_CMD_OP_LSB 8
`define DACSL_CMD_NACK 10
`define DACSL_ST_BUSY 0
`define DACSL_ST_NACK 1

// ==========================================================
// Timing of the generated clock
`define DACSL_CLK_MHZ 250
`define DACSL_QTR_NS 2500
`define DACSL_QTR_CYC ((`DACSL_QTR_NS * `DACSL_CLK_MHZ + 999) / 1000)

`endif

// >>> hw/dacsl_pkg.sv
// Types shared by both ends of the converter command port.
// Assumes dacsl_defines.svh is on the include path.
package dacsl_pkg;

   // ==========================================================
   // Device byte roles, one-hot
   typedef enum logic [6:0]
   {
      DS_IDLE = 7'h01,
      DS_ADDR = 7'h02,
      DS_CTRL = 7'h04,
      DS_DHI = 7'h08,
      DS_DLO = 7'h10,
      DS_TX = 7'h20,
      DS_IGN = 7'h40
   } dacsl_dst_t;

   // Device state, all of it
   typedef struct packed
   {
      logic [2:0] scl_sy;
      logic [2:0] sda_sy;
      logic [1:0] a0_sy;
      dacsl_dst_t st;
      logic [3:0] bitcnt;
      logic [7:0] sh;
      logic rw;
      logic nack;
      logic [1:0] txidx;
      logic sda_oe;
      logic [7:0] ctrl;
      logic [7:0] hi;
      logic [15:0] hold;
      logic [15:0] act;
      logic [15:0] word;
      logic conv;
      logic pdf;
      logic [2:0] pdm;
   } dacsl_dev_t;

   // ==========================================================
   // Controller commands and sequencer states
   typedef enum logic [1:0]
   {
      OP_START = 2'h0,
      OP_STOP = 2'h1,
      OP_WRITE = 2'h2,
      OP_READ = 2'h3
   } dacsl_op_t;

   typedef enum logic [3:0]
   {
      MS_IDLE = 4'h1,
      MS_START = 4'h2,
      MS_STOP = 4'h4,
      MS_BYTE = 4'h8
   } dacsl_mst_st_t;

   // Controller state, all of it
   typedef struct packed
   {
      logic [1:0] sda_sy;
      dacsl_mst_st_t st;
      logic [1:0] step;
      logic [15:0] qcnt;
      logic [3:0] bitcnt;
      logic [8:0] tx;
      logic [8:0] rx;
      logic scl_oe;
      logic sda_oe;
      logic wr;
      logic [31:0] rd;
   } dacsl_mst_t;

endpackage : dacsl_pkg

// >>> hw/dacsl_if.sv
// Two-wire link between the controller and the converter port.
// Open-drain: an enable high pulls the wire low; pullups otherwise.
interface dacsl_if;

   // Pull-down enables from each party
   logic scl_oe;
   logic sda_m_oe;
   logic sda_s_oe;
   // Resolved wire levels
   logic scl;
   logic sda;

   // Wired-AND of the open-drain drivers
   assign scl = ~scl_oe;
   assign sda = ~(sda_m_oe | sda_s_oe);

   // Controller end
   modport ctl
   (
      output scl_oe,
      output sda_m_oe,
      input scl,
      input sda
   );

   // Converter end
   modport dev
   (
      output sda_s_oe,
      input scl,
      input sda
   );

endinterface : dacsl_if

// >>> hw/dacsl_device.sv
// Converter end of the two-wire command port: slave receiver and
// transmitter feeding the converter update logic.
// Assumes the link wires are asynchronous to clk and far slower.
//
// The Avalon-MM slave port and the address map were decided locally.
`include "dacsl_defines.svh"

module dacsl_device
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Two-wire link
   dacsl_if.dev bus,
   // Address strap
   input wire logic address_select_pin,
   // Converter side
   output logic [15:0] conv_word,
   output logic conv_strobe,
   output logic [15:0] active_word,
   output logic powerdown_flag,
   output logic powerdown_mode_bit1,
   output logic powerdown_mode_bit2,
   output logic powerdown_mode_bit3,
   output logic [1:0] update_select,
   output logic broadcast_select
);
   import dacsl_pkg::*;

   // ==========================================================
   // State
   dacsl_dev_t q;      // Registered state
   dacsl_dev_t nxt_q;  // Next state

   // Decoded link events
   logic scl_hi;       // Clock high, settled
   logic scl_rise;     // Clock rising edge seen
   logic scl_fall;     // Clock falling edge seen
   logic start_ev;     // Start or repeated start
   logic stop_ev;      // Stop
   logic rx_bit;       // Settled data level
   logic a0_lvl;       // Settled strap level
   logic active;       // Taking part in a transfer
   logic addr_hit;     // Address byte matches
   logic [7:0] tx_first; // First byte of a read
   logic [7:0] tx_next;  // Following byte of a read

   // ==========================================================
   // Read byte selection
   function automatic logic [7:0] tx_byte
   (
      input logic [1:0] idx,
      input dacsl_dev_t s
   );
      logic [15:0] src;
      src = s.act;
      // Power-down data reaches the holding and word registers, never the active one
      if (s.pdf)
      begin
         src = s.hold;
      end
      if (idx == 2'h0)
      begin
         tx_byte = src[15:8];
      end
      else if (idx == 2'h1)
      begin
         tx_byte = src[7:0];
      end
      else
      begin
         // RULE_16 source in bit 0
         tx_byte = {s.ctrl[7:1], s.pdf};
      end
   endfunction : tx_byte

   // ==========================================================
   // Event decode from the second and third sync stages
   // The first stage is read by nothing but the second.
   always_comb
   begin
      scl_hi = q.scl_sy[1] & q.scl_sy[2];
      // RULE_20 rise and fall
      scl_rise = q.scl_sy[1] & ~q.scl_sy[2];
      scl_fall = ~q.scl_sy[1] & q.scl_sy[2];
      // RULE_18 start and stop
      start_ev = scl_hi & ~q.sda_sy[1] & q.sda_sy[2];
      stop_ev = scl_hi & q.sda_sy[1] & ~q.sda_sy[2];
      rx_bit = q.sda_sy[1];
      a0_lvl = q.a0_sy[1];
      active = (q.st != DS_IDLE) && (q.st != DS_IGN);
      // RULE_03 address compare
      addr_hit = (q.sh[7:1] == {`DACSL_ADDR_HI, a0_lvl, 1'b0});
      // RULE_12 first read byte
      tx_first = tx_byte(2'h0, q);
      tx_next = tx_byte(q.txidx + 2'h1, q);
   end

   // ==========================================================
   // Next-state logic
   always_comb
   begin
      nxt_q = q;
      // Three-flop synchronisers on both link pins, two-flop on the strap
      nxt_q.scl_sy = {q.scl_sy[1:0], bus.scl};
      nxt_q.sda_sy = {q.sda_sy[1:0], bus.sda};
      nxt_q.a0_sy = {q.a0_sy[0], address_select_pin};
      // Conversion strobe lasts one cycle
      nxt_q.conv = 1'b0;
      if (start_ev)
      begin
         // RULE_19 a start always re-arms the address stage
         nxt_q.st = DS_ADDR;
         nxt_q.bitcnt = 4'hf; // Fall ending the start wraps to 0
         nxt_q.sda_oe = 1'b0;
         nxt_q.nack = 1'b0;
      end
      else if (stop_ev)
      begin
         // RULE_18 keep registers, wait for next start
         nxt_q.st = DS_IDLE;
         nxt_q.sda_oe = 1'b0;
      end
      else if (active && scl_rise)
      begin
         if (q.bitcnt == `DACSL_ACK_SLOT)
         begin
            // RULE_15 master answer for the byte just sent
            nxt_q.nack = rx_bit;
         end
         else if (q.st != DS_TX)
         begin
            // RULE_20 sample on rising clock, msb first
            nxt_q.sh = {q.sh[6:0], rx_bit};
         end
      end
      else if (active && scl_fall)
      begin
         if (q.bitcnt == `DACSL_ACK_SLOT)
         begin
            // End of the ninth pulse: release and act
            nxt_q.bitcnt = 4'h0;
            nxt_q.sda_oe = 1'b0;
            unique case (q.st)
               DS_ADDR:
               begin
                  if (q.rw)
                  begin
                     // RULE_11 turn into transmitter
                     nxt_q.st = DS_TX;
                     nxt_q.txidx = 2'h0;
                     nxt_q.sh = tx_first;
                     // RULE_12 first bit while clock low
                     nxt_q.sda_oe = ~tx_first[7];
                  end
                  else
                  begin
                     // RULE_05 control byte comes next
                     nxt_q.st = DS_CTRL;
                  end
               end
               DS_CTRL:
               begin
                  // RULE_05 keep the control byte
                  nxt_q.ctrl = q.sh;
                  nxt_q.st = DS_DHI;
               end
               DS_DHI:
               begin
                  // RULE_06 high byte held for the pair
                  nxt_q.hi = q.sh;
                  nxt_q.st = DS_DLO;
               end
               DS_DLO:
               begin
                  // RULE_07 word complete
                  nxt_q.word = {q.hi, q.sh};
                  nxt_q.hold = {q.hi, q.sh};
                  // RULE_17 conversion at falling edge of acknowledge
                  nxt_q.conv = 1'b1;
                  nxt_q.pdf = q.ctrl[`DACSL_C_PD];
                  if (q.ctrl[`DACSL_C_PD])
                  begin
                     // RULE_10 mode bits from high byte
                     nxt_q.pdm = q.hi[`DACSL_PDM_MSB:`DACSL_PDM_LSB];
                  end
                  else
                  begin
                     nxt_q.act = {q.hi, q.sh};
                  end
                  // RULE_08 another pair may follow
                  nxt_q.st = DS_DHI;
               end
               DS_TX:
               begin
                  if (q.nack || (q.txidx == `DACSL_TX_CTRL))
                  begin
                     // RULE_15 line stays released until stop
                     nxt_q.st = DS_IGN;
                  end
                  else
                  begin
                     // RULE_13 next byte after master acknowledge
                     // RULE_14 control byte comes third
                     nxt_q.txidx = q.txidx + 2'h1;
                     nxt_q.sh = tx_next;
                     nxt_q.sda_oe = ~tx_next[7];
                  end
               end
               DS_IDLE, DS_IGN:
               begin
                  // Not reached while inactive
                  nxt_q.st = q.st;
               end
            endcase
         end
         else
         begin
            nxt_q.bitcnt = q.bitcnt + 4'h1;
            if (q.bitcnt == `DACSL_LAST_BIT)
            begin
               // Eighth bit done: decide the ninth pulse
               if (q.st == DS_ADDR)
               begin
                  nxt_q.rw = q.sh[0];
                  if (addr_hit)
                  begin
                     // RULE_04 pull low through the ninth pulse
                     nxt_q.sda_oe = 1'b1;
                  end
                  else
                  begin
                     // RULE_19 stay off the wire
                     nxt_q.st = DS_IGN;
                  end
               end
               else if (q.st == DS_TX)
               begin
                  // Master owns the ninth pulse of a read
                  nxt_q.sda_oe = 1'b0;
               end
               else
               begin
                  // RULE_04 acknowledge every written byte
                  nxt_q.sda_oe = 1'b1;
               end
            end
            else if (q.st == DS_TX)
            begin
               // RULE_20 change data only while clock is low
               nxt_q.sh = {q.sh[6:0], 1'b0};
               nxt_q.sda_oe = ~q.sh[6];
            end
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         q <= '0;
         q.st <= DS_IDLE;
         // Wires idle high, so no false edge after reset
         q.scl_sy <= `DACSL_SY_RST;
         q.sda_sy <= `DACSL_SY_RST;
      end
      else
      begin
         q <= nxt_q;
      end
   end

   // ==========================================================
   // Outputs straight from the state register
   assign bus.sda_s_oe = q.sda_oe;
   assign conv_word = q.word;
   assign conv_strobe = q.conv;
   assign active_word = q.act;
   assign powerdown_flag = q.pdf;
   assign powerdown_mode_bit1 = q.pdm[2];
   assign powerdown_mode_bit2 = q.pdm[1];
   assign powerdown_mode_bit3 = q.pdm[0];
   assign update_select = q.ctrl[`DACSL_C_LD_MSB:`DACSL_C_LD_LSB];
   assign broadcast_select = q.ctrl[`DACSL_C_BRC];

endmodule : dacsl_device

// >>> hw/dacsl_master.sv
// Controller end of the two-wire link: byte-level sequencer run from
// an Avalon-MM slave with waitrequest.
// Assumes no clock stretching; only this end drives the clock.
`include "dacsl_defines.svh"

module dacsl_master
#(
   parameter int QTR_CYC = `DACSL_QTR_CYC
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Avalon-MM slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Two-wire link
   dacsl_if.ctl bus
);
   import dacsl_pkg::*;

   // ==========================================================
   // State
   dacsl_mst_t q;       // Registered state
   dacsl_mst_t nxt_q;   // Next state
   logic busy;          // Sequencer running
   logic is_cmd;        // Access hits the command word
   logic accept;        // Take the request this cycle
   logic tick;          // End of a quarter bit
   dacsl_op_t op;       // Decoded command
   logic [15:0] qlast;  // Last count of a quarter

   always_comb
   begin
      busy = (q.st != MS_IDLE);
      is_cmd = (address == `DACSL_REG_CMD);
      // A command write waits while a sequence is in flight
      accept = (read | write) & q.wr & ~(write & is_cmd & busy);
      qlast = 16'(QTR_CYC - 1);
      tick = (q.qcnt == qlast);
      op = dacsl_op_t'(writedata[`DACSL_CMD_OP_MSB:`DACSL_CMD_OP_LSB]);
   end

   // ==========================================================
   // Next-state logic
   always_comb
   begin
      nxt_q = q;
      nxt_q.sda_sy = {q.sda_sy[0], bus.sda};
      nxt_q.wr = 1'b1;
      // Bus answer: waitrequest low for one cycle
      if (accept)
      begin
         nxt_q.wr = 1'b0;
         nxt_q.rd = 32'h0;
         if (address == `DACSL_REG_STAT)
         begin
            nxt_q.rd[15:8] = q.rx[8:1];
            nxt_q.rd[`DACSL_ST_NACK] = q.rx[0];
            nxt_q.rd[`DACSL_ST_BUSY] = busy;
         end
      end
      // Sequencer timing
      if (busy)
      begin
         nxt_q.qcnt = tick ? 16'h0 : q.qcnt + 16'h1;
      end
      if (busy && tick)
      begin
         nxt_q.step = q.step + 2'h1;
         unique case (q.st)
            MS_START:
            begin
               // RULE_01 data falls while clock high
               if (q.step == 2'h0) nxt_q.sda_oe = 1'b0;
               if (q.step == 2'h1) nxt_q.scl_oe = 1'b0;
               if (q.step == 2'h2) nxt_q.sda_oe = 1'b1;
               if (q.step == 2'h3) nxt_q.scl_oe = 1'b1;
               if (q.step == 2'h3) nxt_q.st = MS_IDLE;
            end
            MS_STOP:
            begin
               // RULE_09 data rises while clock high
               if (q.step == 2'h0) nxt_q.sda_oe = 1'b1;
               if (q.step == 2'h1) nxt_q.scl_oe = 1'b0;
               if (q.step == 2'h2) nxt_q.sda_oe = 1'b0;
               if (q.step == 2'h3) nxt_q.st = MS_IDLE;
            end
            MS_BYTE:
            begin
               // RULE_02 data set a quarter before clock rises
               if (q.step == 2'h0) nxt_q.sda_oe = ~q.tx[8];
               if (q.step == 2'h1) nxt_q.scl_oe = 1'b0;
               if (q.step == 2'h2) nxt_q.rx = {q.rx[7:0], q.sda_sy[1]};
               if (q.step == 2'h3)
               begin
                  nxt_q.scl_oe = 1'b1;
                  nxt_q.tx = {q.tx[7:0], 1'b1};
                  nxt_q.bitcnt = q.bitcnt + 4'h1;
                  if (q.bitcnt == `DACSL_ACK_SLOT)
                  begin
                     nxt_q.st = MS_IDLE;
                  end
               end
            end
            MS_IDLE:
            begin
               nxt_q.st = MS_IDLE;
            end
         endcase
      end
      // Command takes effect at the edge that sees waitrequest low
      if (write && !q.wr && is_cmd && !busy)
      begin
         nxt_q.step = 2'h0;
         nxt_q.qcnt = 16'h0;
         nxt_q.bitcnt = 4'h0;
         unique case (op)
            OP_START: nxt_q.st = MS_START;
            OP_STOP: nxt_q.st = MS_STOP;
            OP_WRITE:
            begin
               // RULE_04 ninth bit released for the acknowledge
               nxt_q.st = MS_BYTE;
               nxt_q.tx = {writedata[7:0], 1'b1};
            end
            OP_READ:
            begin
               // RULE_15 ninth bit carries the chosen answer
               nxt_q.st = MS_BYTE;
               nxt_q.tx = {8'hff, writedata[`DACSL_CMD_NACK]};
            end
         endcase
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         q <= '0;
         q.st <= MS_IDLE;
         q.wr <= 1'b1;
         q.sda_sy <= 2'h3;
      end
      else
      begin
         q <= nxt_q;
      end
   end

   // Outputs straight from the state register
   assign readdata = q.rd;
   assign waitrequest = q.wr;
   assign bus.scl_oe = q.scl_oe;
   assign bus.sda_m_oe = q.sda_oe;

endmodule : dacsl_master

// >>> tb/dacsl_assertions.sv
// Link checker for the controller and converter port, joined by wire.
// Assumes one clk for both ends and link wires far slower than clk.

module dacsl_link_chk
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Resolved wires and pull-down enables
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_m_oe,
   input wire logic sda_s_oe,
   // Address strap
   input wire logic address_select_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Bit and byte tracking
   logic scl_ff; // Wire levels one cycle back
   logic sda_ff;
   logic [3:0] bitn_ff; // Bit slot, 8 is the ninth
   logic [2:0] bytn_ff; // Bytes since start, saturating
   logic [8:0] sh_ff; // Levels taken at clock rises
   logic hit_ff; // Address matched
   logic rd_ff; // Direction bit of the address
   logic start;
   logic rise;
   logic fall;
   logic [6:0] own; // Own address, strap in bit one
   assign start = scl && scl_ff && sda_ff && !sda;
   assign rise = scl && !scl_ff;
   assign fall = !scl && scl_ff;
   assign own = {5'h13, address_select_pin, 1'b0};

   // Start sets the slot to 15 so the falling edge after it wraps to 0
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         scl_ff <= 1'b1;
         sda_ff <= 1'b1;
         bitn_ff <= 4'h0;
         bytn_ff <= 3'h0;
         sh_ff <= 9'h000;
         hit_ff <= 1'b0;
         rd_ff <= 1'b0;
      end
      else
      begin
         scl_ff <= scl;
         sda_ff <= sda;
         if (start)
         begin
            bitn_ff <= 4'hf;
            bytn_ff <= 3'h0;
            hit_ff <= 1'b0;
            rd_ff <= 1'b0;
         end
         else if (rise)
            sh_ff <= {sh_ff[7:0], sda};
         else if (fall && bitn_ff != 4'h8)
            bitn_ff <= bitn_ff + 4'h1;
         else if (fall)
         begin
            bitn_ff <= 4'h0;
            bytn_ff <= (bytn_ff == 3'h7) ? bytn_ff : bytn_ff + 3'h1;
            hit_ff <= (bytn_ff == 3'h0) ? (sh_ff[8:2] == own) : hit_ff;
            rd_ff <= (bytn_ff == 3'h0) ? sh_ff[1] : rd_ff;
         end
      end
   end

   // ==========================================================
   // Link properties
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_ack_own_addr: assert property
      (rise && bitn_ff == 4'h8 && bytn_ff == 3'h0 && sh_ff[7:1] == own
      |-> sda_s_oe) else $error("own address not acknowledged");
   a_quiet_other_addr: assert property
      ((bytn_ff != 3'h0 && !hit_ff) || (rise && bitn_ff == 4'h8 &&
      bytn_ff == 3'h0 && sh_ff[7:1] != own) |-> !sda_s_oe)
      else $error("device drove after foreign address");
   a_ack_data_bytes: assert property
      (rise && bitn_ff == 4'h8 && bytn_ff != 3'h0 && hit_ff && !rd_ff
      |-> sda_s_oe) else $error("written byte not acknowledged");
   a_dev_moves_low: assert property
      ($changed(sda_s_oe) |-> !scl)
      else $error("device moved data while clock high");
   a_read_release: assert property
      (scl && hit_ff && rd_ff && bytn_ff >= 3'h4 |-> !sda_s_oe)
      else $error("device kept data line after third byte");
   a_master_quiet_tx: assert property
      (scl && hit_ff && rd_ff && bytn_ff != 3'h0 && bytn_ff < 3'h4 &&
      bitn_ff < 4'h8 |-> !sda_m_oe) else $error("master drove read bit");
   a_ninth_free: assert property
      (scl && bitn_ff == 4'h8 && (bytn_ff == 3'h0 || !rd_ff) |-> !sda_m_oe)
      else $error("master drove ninth slot");
   a_steady_high: assert property
      ($changed(sda_m_oe) && scl && scl_ff |-> bitn_ff == 4'h0)
      else $error("master moved data in mid bit");
   a_start_by_master: assert property
      (start |-> sda_m_oe) else $error("start not made by master");

   // Main scenarios reached
   c_write_ack: cover property (rise && bitn_ff == 4'h8 && hit_ff && !rd_ff);
   c_foreign: cover property (bytn_ff == 3'h1 && !hit_ff);
   c_read_end: cover property (hit_ff && rd_ff && bytn_ff == 3'h4);

endmodule : dacsl_link_chk

// >>> tb/dacsl_tb.sv
// Bench joining controller and converter port over the link; orders go
// through the controller's Avalon-MM registers. Needs dacsl_defines.svh.
`include "dacsl_defines.svh"

module dacsl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dacsl_pkg::*;

   // ==========================================================
   // Signals and instances
   logic clk;
   logic rst_n;
   logic [3:0] address; // Avalon request
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [31:0] readdata; // Avalon answer
   logic waitrequest;
   logic address_select_pin;
   logic [15:0] conv_word; // Converter side
   logic conv_strobe;
   logic [15:0] active_word;
   logic powerdown_flag;
   logic powerdown_mode_bit1;
   logic powerdown_mode_bit2;
   logic powerdown_mode_bit3;
   logic [1:0] update_select;
   logic broadcast_select;
   logic [31:0] st; // Last status word
   int miscompares;
   int tests_run;
   int strobes; // Conversion pulses seen

   dacsl_if dacsl_if_i ();
   // Short quarter keeps each byte near 300 cycles
   dacsl_master #(.QTR_CYC(8)) dacsl_master_i (.clk, .rst_n, .address,
      .read, .write, .writedata, .readdata, .waitrequest, .bus(dacsl_if_i));
   dacsl_device dacsl_device_i (.clk, .rst_n, .bus(dacsl_if_i),
      .address_select_pin, .conv_word, .conv_strobe, .active_word,
      .powerdown_flag, .powerdown_mode_bit1, .powerdown_mode_bit2,
      .powerdown_mode_bit3, .update_select, .broadcast_select);
   dacsl_link_chk dacsl_link_chk_i (.clk, .rst_n, .scl(dacsl_if_i.scl),
      .sda(dacsl_if_i.sda), .sda_m_oe(dacsl_if_i.sda_m_oe),
      .sda_s_oe(dacsl_if_i.sda_s_oe), .address_select_pin);

   // 250 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Counts pulses so a missing or doubled one shows
   always @(posedge clk)
      if (conv_strobe === 1'b1)
         strobes++;

   // ==========================================================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic end_of_test();
      if (miscompares == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_of_test

   // One Avalon cycle, held until waitrequest is sampled low
   task automatic av(input logic w, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= d;
      do
         @(posedge clk);
      while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask : av

   // One link command, then status polled until idle
   task automatic op(input dacsl_op_t o, input logic [7:0] b, input logic n);
      logic [31:0] q;
      av(1'b1, `DACSL_REG_CMD, {21'h0, n, o, b}, q);
      do
         av(1'b0, `DACSL_REG_STAT, 32'h0, st);
      while (st[`DACSL_ST_BUSY] !== 1'b0);
   endtask : op

   // Writes a byte and compares the ninth-slot level
   task automatic wb(input logic [7:0] b, input logic e);
      op(OP_WRITE, b, 1'b0);
      chk({31'h0, st[`DACSL_ST_NACK]}, {31'h0, e});
   endtask : wb

   // Full read: high, low, control; the last one refused
   task automatic rd3(input logic [7:0] a, input logic [23:0] e);
      op(OP_START, 8'h00, 1'b0);
      wb(a, 1'b0);
      for (int i = 2; i >= 0; i--)
      begin
         op(OP_READ, 8'h00, i == 0);
         chk({24'h0, st[15:8]}, {24'h0, e[i*8 +: 8]});
      end
      op(OP_STOP, 8'h00, 1'b0);
   endtask : rd3

   // ==========================================================
   // Main sequence
   initial
   begin
      rst_n = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 4'h0;
      writedata = 32'h0;
      address_select_pin = 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      chk({30'h0, dacsl_if_i.scl, dacsl_if_i.sda}, 32'h3);
      av(1'b0, 4'h8, 32'h0, st);
      chk(st, 32'h0);
      // Two words in one transfer, then an odd high byte
      op(OP_START, 8'h00, 1'b0);
      wb(8'h98, 1'b0);
      wb(8'h34, 1'b0);
      wb(8'ha5, 1'b0);
      wb(8'h5a, 1'b0);
      wb(8'h12, 1'b0);
      wb(8'h34, 1'b0);
      op(OP_START, 8'h00, 1'b0);
      chk(strobes, 2);
      chk({16'h0, conv_word}, 32'h1234);
      chk({29'h0, update_select, broadcast_select}, 32'h7);
      wb(8'h98, 1'b0);
      wb(8'h34, 1'b0);
      wb(8'hff, 1'b0);
      op(OP_STOP, 8'h00, 1'b0);
      chk(strobes, 2);
      chk({16'h0, active_word}, 32'h1234);
      rd3(8'h99, 24'h123434);
      // Power-down word lands in the holding side only
      op(OP_START, 8'h00, 1'b0);
      wb(8'h98, 1'b0);
      wb(8'h01, 1'b0);
      wb(8'ha0, 1'b0);
      wb(8'h00, 1'b0);
      op(OP_STOP, 8'h00, 1'b0);
      chk(strobes, 3);
      chk({28'h0, powerdown_flag, powerdown_mode_bit1, powerdown_mode_bit2,
         powerdown_mode_bit3}, 32'hd);
      chk({16'h0, active_word}, 32'h1234);
      rd3(8'h99, 24'ha00001);
      // Foreign address ignored, then strap moves the own address
      op(OP_START, 8'h00, 1'b0);
      wb(8'h9c, 1'b1);
      wb(8'h00, 1'b1);
      op(OP_STOP, 8'h00, 1'b0);
      address_select_pin <= 1'b1;
      op(OP_START, 8'h00, 1'b0);
      wb(8'h9c, 1'b0);
      wb(8'h00, 1'b0);
      wb(8'hbe, 1'b0);
      wb(8'hef, 1'b0);
      op(OP_STOP, 8'h00, 1'b0);
      chk(strobes, 4);
      chk({16'h0, active_word}, 32'hbeef);
      chk({31'h0, powerdown_flag}, 32'h0);
      rd3(8'h9d, 24'hbeef00);
      end_of_test();
   end

   // Whole run is near 10000 cycles; a hang ends here
   initial
   begin
      repeat (60000) @(posedge clk);
      miscompares++;
      end_of_test();
   end

endmodule : dacsl_tb
